// ---- logic/pic_unit.v ----
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "pic_consts.vh"
module pic_unit
#(
  parameter NUM_PERIPH = 5
)
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NUM_PERIPH-1:0] periph_irq,
  input wire [2:0] timer_irq,
  input wire ext_request_line_0,
  input wire ext_request_line_1,
  input wire ext_fast_request_pin,
  output wire core_fast_request_n,
  output wire core_normal_request_n,
  output wire irq
);

  // ----------------------------------------------------------------
  // Source map
  // ----------------------------------------------------------------
  localparam NUM_INT = NUM_PERIPH + 3;
  localparam NUM_SRC = NUM_INT + 2;
  localparam IDX_W = 5;

  reg [31:0] mode_reg;
  reg [3:0] ext_trig;
  reg [29:0] level_lo;
  reg [29:0] level_hi;
  reg [31:0] mask_reg;
  reg [2:0] fast_ctrl;
  reg cur_valid;
  reg [IDX_W-1:0] cur_idx;
  reg [2:0] cur_level;
  reg [NUM_SRC-1:0] ack_pulse;
  reg fast_ack;

  wire [NUM_SRC-1:0] raw_src;
  wire [NUM_SRC-1:0] pending;
  wire [NUM_SRC-1:0] fired;
  wire [NUM_SRC-1:0] enabled;
  wire [59:0] level_all;
  wire fast_pending;
  wire fast_fired;

  // Peripheral sources first, timers next, external lines last
  assign raw_src = {ext_request_line_1, ext_request_line_0, timer_irq, periph_irq};
  assign level_all = {level_hi, level_lo};
  assign enabled = pending & mask_reg[NUM_SRC-1:0];

  // ----------------------------------------------------------------
  // Trigger detection per source
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g = g + 1)
    begin : g_src
      wire [1:0] trig_sel;
      if (g < NUM_INT)
      begin : g_int
        // Internal: bit set selects rising edge, else high level
        assign trig_sel = mode_reg[g] ? `PIC_TRIG_RISE : `PIC_TRIG_HIGH;
      end
      else
      begin : g_ext
        assign trig_sel = ext_trig[2*(g-NUM_INT) +: 2];
      end
      pic_source u_src
      (
        .pclk(pclk),
        .presetn(presetn),
        .raw(raw_src[g]),
        .trig(trig_sel),
        .clear(ack_pulse[g]),
        .fired(fired[g]),
        .pending(pending[g])
      );
    end
  endgenerate

  // Fast source is kept apart from every other source
  pic_source u_fast
  (
    .pclk(pclk),
    .presetn(presetn),
    .raw(ext_fast_request_pin),
    .trig(fast_ctrl[2:1]),
    .clear(fast_ack),
    .fired(fast_fired),
    .pending(fast_pending)
  );

  // ----------------------------------------------------------------
  // Priority encoder
  // ----------------------------------------------------------------
  reg next_valid;
  reg [IDX_W-1:0] next_idx;
  reg [2:0] next_level;
  integer i;

  // Scan from the top so equal levels resolve to the lowest number
  always @*
  begin
    next_valid = 1'b0;
    next_idx = {IDX_W{1'b0}};
    next_level = 3'h0;
    for (i = NUM_SRC - 1; i >= 0; i = i - 1)
    begin
      if (enabled[i] && (!next_valid || level_all[3*i +: 3] >= next_level))
      begin
        next_valid = 1'b1;
        next_idx = i[IDX_W-1:0];
        next_level = level_all[3*i +: 3];
      end
    end
  end

  // Registered current winner
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_valid <= 1'b0;
      cur_idx <= {IDX_W{1'b0}};
      cur_level <= 3'h0;
    end
    else
    begin
      cur_valid <= next_valid;
      cur_idx <= next_idx;
      cur_level <= next_level;
    end
  end

  // ----------------------------------------------------------------
  // Core request outputs, active low; irq is active high
  // ----------------------------------------------------------------
  assign core_normal_request_n = ~cur_valid;
  assign core_fast_request_n = ~(fast_pending & fast_ctrl[`PIC_FAST_EN_BIT]);
  assign irq = |enabled;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire wr_en;
  wire rd_en;
  reg addr_ok;

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pslverr = psel & penable & ~addr_ok;

  // Address decode
  always @*
  begin
    case (paddr)
      `PIC_OFF_MODE, `PIC_OFF_EXT_TRIG, `PIC_OFF_LEVEL_LO, `PIC_OFF_LEVEL_HI,
      `PIC_OFF_STATUS, `PIC_OFF_MASK, `PIC_OFF_CURRENT, `PIC_OFF_PEND_RAW,
      `PIC_OFF_ACK, `PIC_OFF_FAST_CTRL:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  // Register writes and clear pulses
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= `PIC_RST_WORD;
      ext_trig <= 4'h0;
      level_lo <= 30'h00000000;
      level_hi <= 30'h00000000;
      mask_reg <= `PIC_RST_WORD;
      fast_ctrl <= 3'h0;
      ack_pulse <= {NUM_SRC{1'b0}};
      fast_ack <= 1'b0;
    end
    else
    begin
      ack_pulse <= {NUM_SRC{1'b0}};
      fast_ack <= 1'b0;
      if (wr_en)
      begin
        case (paddr)
          `PIC_OFF_MODE: mode_reg <= pwdata;
          `PIC_OFF_EXT_TRIG: ext_trig <= pwdata[3:0];
          `PIC_OFF_LEVEL_LO: level_lo <= pwdata[29:0];
          `PIC_OFF_LEVEL_HI: level_hi <= pwdata[29:0];
          `PIC_OFF_MASK: mask_reg <= pwdata;
          `PIC_OFF_STATUS: ack_pulse <= pwdata[NUM_SRC-1:0];
          `PIC_OFF_FAST_CTRL:
          begin
            fast_ctrl <= pwdata[2:0];
            fast_ack <= pwdata[3];
          end
          `PIC_OFF_ACK:
            if (cur_valid)
              ack_pulse <= {{(NUM_SRC-1){1'b0}}, 1'b1} << cur_idx;
          default: ;
        endcase
      end
    end
  end

  // Read data, registered at the access edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en)
    begin
      case (paddr)
        `PIC_OFF_MODE: prdata <= mode_reg;
        `PIC_OFF_EXT_TRIG: prdata <= {28'h0000000, ext_trig};
        `PIC_OFF_LEVEL_LO: prdata <= {2'h0, level_lo};
        `PIC_OFF_LEVEL_HI: prdata <= {2'h0, level_hi};
        `PIC_OFF_STATUS: prdata <= {{(32-NUM_SRC){1'b0}}, pending};
        `PIC_OFF_MASK: prdata <= mask_reg;
        `PIC_OFF_CURRENT: prdata <= {cur_valid, 20'h00000, cur_level, 3'h0, cur_idx};
        `PIC_OFF_PEND_RAW: prdata <= {{(32-NUM_SRC){1'b0}}, fired};
        `PIC_OFF_FAST_CTRL: prdata <= {27'h0000000, fast_fired, fast_pending, fast_ctrl};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // pic_unit

// ---- include/pic_consts.vh ----
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PIC_OFF_MODE 12'h000
`define PIC_OFF_EXT_TRIG 12'h004
`define PIC_OFF_LEVEL_LO 12'h008
`define PIC_OFF_LEVEL_HI 12'h00C
`define PIC_OFF_STATUS 12'h010
`define PIC_OFF_MASK 12'h014
`define PIC_OFF_CURRENT 12'h018
`define PIC_OFF_PEND_RAW 12'h01C
`define PIC_OFF_ACK 12'h020
`define PIC_OFF_FAST_CTRL 12'h024

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define PIC_LEVEL_W 3
`define PIC_TRIG_W 2
`define PIC_TRIG_HIGH 2'h0
`define PIC_TRIG_LOW 2'h1
`define PIC_TRIG_RISE 2'h2
`define PIC_TRIG_FALL 2'h3
`define PIC_CUR_VALID_BIT 31
`define PIC_CUR_LEVEL_LSB 8
`define PIC_FAST_EN_BIT 0
`define PIC_FAST_TRIG_LSB 1
`define PIC_RST_WORD 32'h00000000

`endif

// ---- logic/pic_source.v ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// One interrupt source: trigger detection and sticky pending bit
// ----------------------------------------------------------------
module pic_source
(
  input wire pclk,
  input wire presetn,
  input wire raw,
  input wire [1:0] trig,
  input wire clear,
  output wire fired,
  output reg pending
);

  reg raw_d;

  // Level or edge qualification of the raw input
  assign fired = (trig == 2'h0) ? raw :
                 (trig == 2'h1) ? ~raw :
                 (trig == 2'h2) ? (raw & ~raw_d) :
                 (~raw & raw_d);

  // Pending latch, a new event wins over a clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      raw_d <= 1'b0;
      pending <= 1'b0;
    end
    else
    begin
      raw_d <= raw;
      if (fired)
        pending <= 1'b1;
      else if (clear)
        pending <= 1'b0;
    end
  end

endmodule // pic_source

// ---- dv/pic_unit_sva.sv ----
`timescale 1ns/10ps
// --------------------
// Port checker
// --------------------
module pic_unit_sva
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic pslverr,
  input logic ext_fast_request_pin,
  input logic core_fast_request_n,
  input logic core_normal_request_n,
  input logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Access phase and decode
  wire ac = psel && penable;
  wire hit = paddr <= 12'h024 && paddr[1:0] == 2'h0;
  wire rd = ac && !pwrite;
  property p_bad; ac && !hit |-> pslverr; endproperty
  property p_ok; ac && hit |-> !pslverr; endproperty
  property p_zero; rd && pslverr |=> prdata == 32'h0; endproperty
  property p_hold; !rd |=> $stable(prdata); endproperty
  property p_cur; rd && paddr == 12'h018 |=> prdata[31] == !$past(core_normal_request_n);
  endproperty
  property p_fast; ($stable(ext_fast_request_pin) && !psel)[*5]
    |=> $stable(core_fast_request_n); endproperty
  property p_fell; $fell(core_normal_request_n) && !$past(psel) |-> irq; endproperty
  property p_on; (irq && !psel)[*3] |-> !core_normal_request_n; endproperty
  a_bad: assert property (p_bad) else $error("no error");
  a_ok: assert property (p_ok) else $error("bad error");
  a_zero: assert property (p_zero) else $error("data");
  a_hold: assert property (p_hold) else $error("data moved");
  a_cur: assert property (p_cur) else $error("valid");
  a_fast: assert property (p_fast) else $error("fast moved");
  a_fell: assert property (p_fell) else $error("normal");
  a_on: assert property (p_on) else $error("no normal");
  c_err: cover property (ac && pslverr);
  c_fast: cover property ($fell(core_fast_request_n));
  c_norm: cover property ($fell(core_normal_request_n));
endmodule // pic_unit_sva

bind pic_unit pic_unit_sva u_sva
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .irq(irq),
  .ext_fast_request_pin(ext_fast_request_pin), .core_fast_request_n(core_fast_request_n),
  .core_normal_request_n(core_normal_request_n)
);

// ---- dv/pic_core_model.sv ----
`timescale 1ns/10ps
// --------------------
// Core side
// --------------------
module pic_core_model
(
  input logic pclk,
  input logic presetn,
  input logic fast_n,
  output int fast_seen
);
  logic fq;
  // Counts fast requests taken
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fq <= 1'b1;
      fast_seen <= 0;
    end
    else
    begin
      fq <= fast_n;
      if (fq && !fast_n) fast_seen <= fast_seen + 1;
    end
  end
endmodule // pic_core_model

// ---- dv/test_pic_unit.sv ----
`timescale 1ns/10ps
// --------------------
// Bench
// --------------------
module test_pic_unit;
  localparam logic [31:0] lev = 32'h1439F16A;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd, ex;
  logic [9:0] src = 10'h000;
  logic fpin = 1'b0, err;
  logic [13:0] rows [16];
  wire [31:0] prdata;
  wire pready, pslverr, fast_n, normal_n, irq;
  int num_errors = 0, n_compared = 0, cyc = 0, fast_seen;
  pic_unit dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_irq(src[4:0]), .timer_irq(src[7:5]), .ext_request_line_0(src[8]),
    .ext_request_line_1(src[9]), .ext_fast_request_pin(fpin), .irq(irq),
    .core_fast_request_n(fast_n), .core_normal_request_n(normal_n)
  );
  pic_core_model core
  (
    .pclk(pclk), .presetn(presetn), .fast_n(fast_n), .fast_seen(fast_seen)
  );
  // Clock and watchdog
  always #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      report_and_stop;
    end
  end
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task chk(input logic [32:0] s, input logic [32:0] e);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: %h, wanted %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    tick(1);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    do tick(1); while (pready !== 1'b1);
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
    rd = prdata;
  endtask
  task clr;
    apb(1'b1, 12'h010, 32'h000003FF);
    apb(1'b1, 12'h020, 32'h00000000);
  endtask
  task report_and_stop;
    $display("compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rows = '{14'h0010, 14'h0021, 14'h0042, 14'h0083, 14'h0104, 14'h0205, 14'h0406, 14'h0807,
      14'h1008, 14'h2009, 14'h0061, 14'h0114, 14'h1406, 14'h0466, 14'h2010, 14'h3208};
    tick(4);
    presetn <= 1'b1;
    for (int a = 0; a < 40; a += 4)
    begin
      apb(1'b0, a[11:0], 32'h0);
      chk({err, rd}, 32'h0);
    end
    chk({fast_n, normal_n, irq}, 32'h6);
    $display("done reset");
    apb(1'b1, 12'h008, lev);
    apb(1'b1, 12'h014, 32'h3FF);
    for (int k = 0; k < 16; k++)
    begin
      src <= rows[k][13:4];
      tick(4);
      apb(1'b0, 12'h018, 32'h0);
      ex = 32'h80000000 | (((lev >> (3 * rows[k][3:0])) & 32'h7) << 8) | rows[k][3:0];
      chk(rd & 32'h8000071F, ex);
      chk({fast_n, normal_n, irq}, 32'h5);
      src <= 10'h000;
      clr;
      tick(3);
      chk({normal_n, irq}, 32'h2);
    end
    $display("done rows");
    apb(1'b1, 12'h000, 32'h1);
    src[0] <= 1'b1;
    tick(3);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    src[0] <= 1'b0;
    clr;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h014, 32'h0);
    src[5] <= 1'b1;
    tick(4);
    chk({normal_n, irq}, 32'h2);
    apb(1'b1, 12'h014, 32'h20);
    tick(3);
    chk({normal_n, irq}, 32'h1);
    src[5] <= 1'b0;
    clr;
    $display("done edge and mask");
    for (int t = 0; t < 4; t++)
    begin
      src[8] <= t[0];
      apb(1'b1, 12'h004, t);
      clr;
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h0);
      src[8] <= ~t[0];
      tick(2);
      src[8] <= t[0];
      tick(3);
      apb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h100);
    end
    src[8] <= 1'b0;
    apb(1'b1, 12'h004, 32'h0);
    clr;
    $display("done triggers");
    apb(1'b1, 12'h024, 32'h1);
    fpin <= 1'b1;
    tick(4);
    chk({fast_n, normal_n}, 32'h1);
    fpin <= 1'b0;
    apb(1'b1, 12'h024, 32'h9);
    tick(3);
    chk({fast_n, fast_seen[7:0]}, 32'h101);
    apb(1'b1, 12'h100, 32'hFFFFFFFF);
    apb(1'b0, 12'h100, 32'h0);
    chk({err, rd}, 33'h100000000);
    $display("done fast and decode");
    report_and_stop;
  end
endmodule // test_pic_unit
